// >>> rtl/mipc_defines.vh
// Purpose: Shared constants of the I/O port block
// Assumes: Register index times four gives the Avalon byte address
// Notes: Data latches reset to zero
`ifndef MIPC_DEFINES_VH
`define MIPC_DEFINES_VH

// Register indexes, byte address is four times the index
`define MIPC_P0_IDX 8'he0
`define MIPC_P1_IDX 8'he1
`define MIPC_PD0_IDX 8'he2
`define MIPC_PD1_IDX 8'he3
`define MIPC_P2_IDX 8'he4
`define MIPC_P3_IDX 8'he5
`define MIPC_PD2_IDX 8'he6
`define MIPC_PD3_IDX 8'he7
`define MIPC_P4_IDX 8'he8
`define MIPC_PD4_IDX 8'hea
`define MIPC_PULLUP_SELECT_LOW_IDX 8'hf0
`define MIPC_PULLUP_SELECT_HIGH_IDX 8'hf1
`define MIPC_P1DRV_IDX 8'hf2
`define MIPC_P2DRV_IDX 8'hf3
`define MIPC_DRV0_IDX 8'hf4
`define MIPC_DRV1_IDX 8'hf5
`define MIPC_THR0_IDX 8'hf6
`define MIPC_THR1_IDX 8'hf7
`define MIPC_PROT_IDX 8'hf8

// Port numbers and the code for no port
`define MIPC_PORT_NONE 3'h7
`define MIPC_PORT0 3'h0
`define MIPC_PORT1 3'h1
`define MIPC_PORT2 3'h2
`define MIPC_PORT3 3'h3
`define MIPC_PORT4 3'h4

// Implemented I/O bits, port 4 in the top byte
`define MIPC_IO_MASK 40'he0ba07ffff
// Readable data bits, adds the input-only pin of port 4
`define MIPC_RD_MASK 40'he4ba07ffff
// Pins shared with the main crystal
`define MIPC_XTAL_MASK 40'hc000000000
// Input-only analog shared pin
`define MIPC_ANALOG_BIT 34

// Field positions and widths
`define MIPC_PULLUP_SELECT_LOW_W 4
`define MIPC_PULLUP_SELECT_HIGH_W 4
`define MIPC_P2DRV_W 3
`define MIPC_DRV0_W 2
`define MIPC_DRV1_W 3
`define MIPC_THR0_W 6
`define MIPC_THR1_W 4
`define MIPC_PROT_UNLOCK_BIT 2

// Reset values
`define MIPC_BYTE_RST 8'h00
`define MIPC_DIR_RST 40'h0000000000
`define MIPC_LAT_RST 40'h0000000000
`define MIPC_RD_ZERO 32'h00000000

`endif

// >>> rtl/mipc_pin_bank.v
// Purpose: Registered pin drivers for one eight-bit port
// Assumes: Pins are synchronous to mclk
// Notes: Output enable is active low
`timescale 1ns/1ps
`default_nettype none
`include "mipc_defines.vh"
module mipc_pin_bank
(
    input wire mclk,
    input wire rst,
    input wire [7:0] io_en,
    input wire [7:0] dir,
    input wire [7:0] latch,
    input wire [7:0] periph_en,
    input wire [7:0] periph_val,
    input wire [7:0] pu_sel,
    input wire [7:0] drv_sel,
    output reg [7:0] pin_out_q,
    output reg [7:0] pin_oe_n_q,
    output reg [7:0] pin_pu_q,
    output reg [7:0] pin_drv_q
);
    reg [7:0] drive_en;
    reg [7:0] out_d;

    always @*
    begin
        // Peripheral output overrides the direction bit
        drive_en = io_en & (dir | periph_en);
        out_d = (periph_en & periph_val) | (~periph_en & latch);
    end

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pin_out_q <= `MIPC_BYTE_RST;
            pin_oe_n_q <= ~`MIPC_BYTE_RST;
            pin_pu_q <= `MIPC_BYTE_RST;
            pin_drv_q <= `MIPC_BYTE_RST;
        end
        else
        begin
            pin_out_q <= out_d & drive_en;
            pin_oe_n_q <= ~drive_en;
            // Pull-up only while the pin is not driven
            pin_pu_q <= pu_sel & io_en & ~drive_en;
            pin_drv_q <= drv_sel & io_en;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/mipc_port_ctrl.v
// Purpose: GPIO port control with an Avalon-MM register slave
// Assumes: One cycle of waitrequest high before every answer
// Notes: Pins are flattened, port n occupies bits 8n+7 to 8n
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "mipc_defines.vh"
module mipc_port_ctrl
#(
    parameter ADDR_W = 10
)
(
    input wire mclk,
    input wire rst,
    input wire [ADDR_W-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire [39:0] pin_in,
    output wire [39:0] pin_out,
    output wire [39:0] pin_oe_n,
    output wire [39:0] pin_pullup,
    output wire [39:0] pin_drive_high,
    output reg [5:0] thresh_code_low,
    output reg [3:0] thresh_code_high,
    input wire [39:0] periph_out_en,
    input wire [39:0] periph_out,
    input wire xtal_in_use,
    input wire adc_in_use
);
    reg [39:0] dir_q;
    reg [39:0] lat_q;
    reg [3:0] pullup_select_low_q;
    reg [3:0] pullup_select_high_q;
    reg [7:0] p1drv_q;
    reg [2:0] p2drv_q;
    reg [1:0] drv0_q;
    reg [2:0] drv1_q;
    reg unlock_q;
    reg [31:0] rd_d;
    reg [39:0] io_en;
    reg [39:0] rd_pins;
    reg [39:0] pu_vec;
    reg [39:0] drv_vec;
    wire [7:0] idx;
    wire req;
    wire commit;
    wire wr_commit;
    wire lane0;
    wire [2:0] dport;
    wire [2:0] pport;

    assign idx = avs_address[9:2];
    assign req = avs_read | avs_write;
    assign commit = req & ~avs_waitrequest;
    assign wr_commit = commit & avs_write;
    assign lane0 = avs_byteenable[0];

    // Maps a register index to the data register's port
    function [2:0] data_port;
        input [7:0] i;
        begin
            case (i)
                `MIPC_P0_IDX: data_port = `MIPC_PORT0;
                `MIPC_P1_IDX: data_port = `MIPC_PORT1;
                `MIPC_P2_IDX: data_port = `MIPC_PORT2;
                `MIPC_P3_IDX: data_port = `MIPC_PORT3;
                `MIPC_P4_IDX: data_port = `MIPC_PORT4;
                default: data_port = `MIPC_PORT_NONE;
            endcase
        end
    endfunction

    // Maps a register index to the direction register's port
    function [2:0] dir_port;
        input [7:0] i;
        begin
            case (i)
                `MIPC_PD0_IDX: dir_port = `MIPC_PORT0;
                `MIPC_PD1_IDX: dir_port = `MIPC_PORT1;
                `MIPC_PD2_IDX: dir_port = `MIPC_PORT2;
                `MIPC_PD3_IDX: dir_port = `MIPC_PORT3;
                `MIPC_PD4_IDX: dir_port = `MIPC_PORT4;
                default: dir_port = `MIPC_PORT_NONE;
            endcase
        end
    endfunction

    // Byte of a 40-bit port vector
    function [7:0] port_byte;
        input [39:0] v;
        input [2:0] p;
        begin
            case (p)
                `MIPC_PORT0: port_byte = v[7:0];
                `MIPC_PORT1: port_byte = v[15:8];
                `MIPC_PORT2: port_byte = v[23:16];
                `MIPC_PORT3: port_byte = v[31:24];
                `MIPC_PORT4: port_byte = v[39:32];
                default: port_byte = `MIPC_BYTE_RST;
            endcase
        end
    endfunction

    // Replaces one byte of a port vector
    function [39:0] put_byte;
        input [39:0] v;
        input [2:0] p;
        input [7:0] b;
        reg [39:0] r;
        begin
            r = v;
            case (p)
                `MIPC_PORT0: r[7:0] = b;
                `MIPC_PORT1: r[15:8] = b;
                `MIPC_PORT2: r[23:16] = b;
                `MIPC_PORT3: r[31:24] = b;
                `MIPC_PORT4: r[39:32] = b;
                default: r = v;
            endcase
            put_byte = r;
        end
    endfunction

    // Write byte cut to the implemented bits of one port
    function [7:0] io_byte;
        input [7:0] b;
        input [2:0] p;
        begin
            io_byte = b & port_byte(`MIPC_IO_MASK, p);
        end
    endfunction

    // Spreads port 4 and the two port 3 group bits over their pins
    function [15:0] upper_groups;
        input [2:0] g;
        begin
            upper_groups = {{3{g[2]}}, 5'h00,
                            g[1], 1'b0, g[1], g[1],
                            g[0], 1'b0, g[0], 1'b0};
        end
    endfunction

    assign dport = data_port(idx);
    assign pport = dir_port(idx);

    always @*
    begin
        // Crystal pins leave GPIO while the oscillator runs
        io_en = `MIPC_IO_MASK;
        if (xtal_in_use)
        begin
            io_en = `MIPC_IO_MASK & ~`MIPC_XTAL_MASK;
        end
        // Input mode reads the pin, output mode the latch
        rd_pins = ((dir_q & lat_q) | (~dir_q & pin_in)) & io_en;
        // Analog shared pin is input only, read while ADC is idle
        rd_pins[`MIPC_ANALOG_BIT] = ~adc_in_use
            & pin_in[`MIPC_ANALOG_BIT];
        rd_pins = rd_pins & `MIPC_RD_MASK;
    end

    always @*
    begin
        // Pull-up groups: nibbles of ports 0 and 1, groups of 2, 3 and 4
        pu_vec = {upper_groups(pullup_select_high_q[3:1]),
                  5'h00, {3{pullup_select_high_q[0]}},
                  {4{pullup_select_low_q[3]}}, {4{pullup_select_low_q[2]}},
                  {4{pullup_select_low_q[1]}}, {4{pullup_select_low_q[0]}}};
        // Per bit on ports 1 and 2, per group elsewhere
        drv_vec = {upper_groups(drv1_q),
                   5'h00, p2drv_q,
                   p1drv_q,
                   {4{drv0_q[1]}}, {4{drv0_q[0]}}};
    end

    always @*
    begin
        rd_d = `MIPC_RD_ZERO;
        if (dport != `MIPC_PORT_NONE)
        begin
            rd_d[7:0] = port_byte(rd_pins, dport);
        end
        else if (pport != `MIPC_PORT_NONE)
        begin
            rd_d[7:0] = port_byte(dir_q, pport);
        end
        else
        begin
            case (idx)
                `MIPC_PULLUP_SELECT_LOW_IDX: rd_d[3:0] = pullup_select_low_q;
                `MIPC_PULLUP_SELECT_HIGH_IDX: rd_d[3:0] = pullup_select_high_q;
                `MIPC_P1DRV_IDX: rd_d[7:0] = p1drv_q;
                `MIPC_P2DRV_IDX: rd_d[2:0] = p2drv_q;
                `MIPC_DRV0_IDX: rd_d[1:0] = drv0_q;
                `MIPC_DRV1_IDX: rd_d[2:0] = drv1_q;
                `MIPC_THR0_IDX: rd_d[5:0] = thresh_code_low;
                `MIPC_THR1_IDX: rd_d[3:0] = thresh_code_high;
                `MIPC_PROT_IDX:
                    rd_d[`MIPC_PROT_UNLOCK_BIT] = unlock_q;
                default: rd_d = `MIPC_RD_ZERO;
            endcase
        end
    end

    // Avalon handshake, one wait cycle then the answer
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= `MIPC_RD_ZERO;
        end
        else if (req && avs_waitrequest)
        begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= avs_read ? rd_d : `MIPC_RD_ZERO;
        end
        else
        begin
            avs_waitrequest <= 1'b1;
        end
    end

    // Direction, latch and unlock state
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            dir_q <= `MIPC_DIR_RST;
            lat_q <= `MIPC_LAT_RST;
            unlock_q <= 1'b0;
        end
        else if (wr_commit && lane0)
        begin
            // Any other write ends the unlock window
            unlock_q <= (idx == `MIPC_PROT_IDX)
                && avs_writedata[`MIPC_PROT_UNLOCK_BIT];
            if (dport != `MIPC_PORT_NONE)
            begin
                // Latch loads whatever the direction
                lat_q <= put_byte(lat_q, dport,
                    io_byte(avs_writedata[7:0], dport));
            end
            if ((pport != `MIPC_PORT_NONE)
                && ((pport != `MIPC_PORT0) || unlock_q))
            begin
                // Unimplemented bits stay zero
                dir_q <= put_byte(dir_q, pport,
                    io_byte(avs_writedata[7:0], pport));
            end
        end
        else if (wr_commit)
        begin
            unlock_q <= 1'b0;
        end
    end

    // Pull-up, drive and threshold selects
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pullup_select_low_q <= `MIPC_PULLUP_SELECT_LOW_W'h0;
            pullup_select_high_q <= `MIPC_PULLUP_SELECT_HIGH_W'h0;
            p1drv_q <= `MIPC_BYTE_RST;
            p2drv_q <= `MIPC_P2DRV_W'h0;
            drv0_q <= `MIPC_DRV0_W'h0;
            drv1_q <= `MIPC_DRV1_W'h0;
            thresh_code_low <= `MIPC_THR0_W'h0;
            thresh_code_high <= `MIPC_THR1_W'h0;
        end
        else if (wr_commit && lane0)
        begin
            case (idx)
                `MIPC_PULLUP_SELECT_LOW_IDX: pullup_select_low_q <= avs_writedata[3:0];
                `MIPC_PULLUP_SELECT_HIGH_IDX: pullup_select_high_q <= avs_writedata[3:0];
                `MIPC_P1DRV_IDX: p1drv_q <= avs_writedata[7:0];
                `MIPC_P2DRV_IDX: p2drv_q <= avs_writedata[2:0];
                `MIPC_DRV0_IDX: drv0_q <= avs_writedata[1:0];
                `MIPC_DRV1_IDX: drv1_q <= avs_writedata[2:0];
                `MIPC_THR0_IDX:
                    thresh_code_low <= avs_writedata[5:0];
                `MIPC_THR1_IDX:
                    thresh_code_high <= avs_writedata[3:0];
                default:
                begin
                    pullup_select_low_q <= pullup_select_low_q;
                end
            endcase
        end
    end

    // One pin bank per port
    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1)
        begin : bank
            mipc_pin_bank u_bank
            (
                .mclk(mclk),
                .rst(rst),
                .io_en(io_en[8*g +: 8]),
                .dir(dir_q[8*g +: 8]),
                .latch(lat_q[8*g +: 8]),
                .periph_en(periph_out_en[8*g +: 8]),
                .periph_val(periph_out[8*g +: 8]),
                .pu_sel(pu_vec[8*g +: 8]),
                .drv_sel(drv_vec[8*g +: 8]),
                .pin_out_q(pin_out[8*g +: 8]),
                .pin_oe_n_q(pin_oe_n[8*g +: 8]),
                .pin_pu_q(pin_pullup[8*g +: 8]),
                .pin_drv_q(pin_drive_high[8*g +: 8])
            );
        end
    endgenerate
endmodule
`default_nettype wire

// >>> test/mipc_pin_model.sv
// Purpose: External pins and the devices attached to them
// Assumes: Attached devices drive only pins the port leaves undriven
// Notes: Lines with no driver and no pull-up toggle every cycle
`timescale 1ns/1ps
`default_nettype none
module mipc_pin_model
(
    input wire logic mclk,
    input wire logic [39:0] pin_out,
    input wire logic [39:0] pin_oe_n,
    input wire logic [39:0] pin_pullup,
    input wire logic [39:0] ext_drv,
    input wire logic [39:0] ext_val,
    output logic [39:0] pin_in
);
    logic [39:0] float_q = 40'h0;
    wire logic [39:0] ext_m = pin_oe_n & ext_drv;
    wire logic [39:0] float_m = pin_oe_n & ~ext_drv;
    always @(posedge mclk)
        float_q <= ~float_q;
    // Port driver wins, then the attached device, then pull-up or float
    assign pin_in = (~pin_oe_n & pin_out)
        | (ext_m & ext_val)
        | (float_m & (pin_pullup | float_q));
endmodule
`default_nettype wire

// >>> test/mipc_port_ctrl_chk.sv
// Purpose: Concurrent checks on the port control block
// Assumes: Sees only the ports of mipc_port_ctrl
// Notes: Pin outputs lag their cause by one edge
`timescale 1ns/1ps
`default_nettype none
`include "mipc_defines.vh"
module mipc_port_ctrl_chk
#(
    parameter ADDR_W = 10
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [39:0] pin_in,
    input wire logic [39:0] pin_out,
    input wire logic [39:0] pin_oe_n,
    input wire logic [39:0] pin_pullup,
    input wire logic [39:0] pin_drive_high,
    input wire logic [5:0] thresh_code_low,
    input wire logic [3:0] thresh_code_high,
    input wire logic [39:0] periph_out_en,
    input wire logic [39:0] periph_out,
    input wire logic xtal_in_use,
    input wire logic adc_in_use
);
    wire logic rd_ans = avs_read && !avs_waitrequest;
    wire logic [7:0] idx = avs_address[9:2];
    wire logic p4_ans = rd_ans && idx == `MIPC_P4_IDX;
    wire logic [39:0] own_m = periph_out_en & `MIPC_IO_MASK
        & ~({40{xtal_in_use}} & `MIPC_XTAL_MASK);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    property p_answer;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_answer: assert property (p_answer)
        else $error("request not answered next cycle");
    property p_pulse;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("answer longer than one cycle");
    property p_reset;
        $fell(rst) |-> &pin_oe_n && pin_pullup == 40'h0 && avs_waitrequest;
    endproperty
    a_reset: assert property (p_reset)
        else $error("pins not in input mode after reset");
    property p_unmapped;
        rd_ans && idx < 8'he0 |-> avs_readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_adc;
        p4_ans && $past(adc_in_use) |-> avs_readdata[2:0] == 3'h0;
    endproperty
    a_adc: assert property (p_adc)
        else $error("shared analog pin read while converter busy");
    property p_xtal_rd;
        p4_ans && $past(xtal_in_use) |-> avs_readdata[7:6] == 2'b00;
    endproperty
    a_xtal_rd: assert property (p_xtal_rd)
        else $error("crystal pins read as port");
    property p_xtal_pin;
        xtal_in_use && $past(xtal_in_use) |-> pin_oe_n[39:38] == 2'b11;
    endproperty
    a_xtal_pin: assert property (p_xtal_pin)
        else $error("crystal pin driven");
    property p_unimpl;
        &(pin_oe_n | `MIPC_IO_MASK);
    endproperty
    a_unimpl: assert property (p_unimpl)
        else $error("pin without output driven");
    property p_periph;
        !$past(rst) |-> (pin_oe_n & $past(own_m)) == 40'h0
            && ((pin_out ^ $past(periph_out)) & $past(own_m)) == 40'h0;
    endproperty
    a_periph: assert property (p_periph)
        else $error("peripheral output not on pin");
    property p_pull;
        (pin_pullup & ~pin_oe_n) == 40'h0;
    endproperty
    a_pull: assert property (p_pull)
        else $error("pull-up on driven pin");
    c_p4: cover property (p4_ans && xtal_in_use);
    c_dir0: cover property (avs_write && !avs_waitrequest
        && idx == `MIPC_PD0_IDX);
    c_periph: cover property (|(own_m & ~pin_oe_n));
endmodule
bind mipc_port_ctrl mipc_port_ctrl_chk #(.ADDR_W(ADDR_W)) i_chk (
    .mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .pin_in, .pin_out,
    .pin_oe_n, .pin_pullup, .pin_drive_high, .thresh_code_low,
    .thresh_code_high, .periph_out_en, .periph_out, .xtal_in_use,
    .adc_in_use);
`default_nettype wire

// >>> test/testbench.sv
// Purpose: Self-checking bench for the port control block
// Assumes: Pin model closes the loop from pin_out to pin_in
// Notes: Register access is an Avalon-MM master
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [9:0] avs_address = 10'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h1;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [39:0] pin_in, pin_out, pin_oe_n, pin_pullup, pin_drive_high;
    logic [5:0] thresh_code_low;
    logic [3:0] thresh_code_high;
    logic [39:0] periph_out_en = 40'h0;
    logic [39:0] periph_out = 40'h0;
    logic xtal_in_use = 1'b0;
    logic adc_in_use = 1'b0;
    logic [39:0] ext_drv = {40{1'b1}};
    logic [39:0] ext_val = 40'h5c3a96c3e1;
    logic [7:0] di [5] = '{8'he2, 8'he3, 8'he6, 8'he7, 8'hea};
    logic [7:0] mk [5] = '{8'hff, 8'hff, 8'h07, 8'hba, 8'he0};
    logic [7:0] rdv, dm, ex;
    int n_fail = 0;
    int n_compared = 0;
    int cycles = 0;
    mipc_port_ctrl #(.ADDR_W(10)) i_mipc_port_ctrl (
        .mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .pin_in,
        .pin_out, .pin_oe_n, .pin_pullup, .pin_drive_high,
        .thresh_code_low, .thresh_code_high, .periph_out_en, .periph_out,
        .xtal_in_use, .adc_in_use);
    mipc_pin_model i_mipc_pin_model (.mclk, .pin_out, .pin_oe_n,
        .pin_pullup, .ext_drv, .ext_val, .pin_in);
    initial
    begin
        forever #12.5 mclk = ~mclk;
    end
    task automatic stop_test();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One access, entered just after a rising edge
    task automatic bus(input logic w, input logic [7:0] idx,
        input logic [7:0] d);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, d};
        avs_read <= !w;
        avs_write <= w;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0)
            @(posedge mclk);
        rdv = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            n_fail++;
            stop_test();
        end
    end
    initial
    begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk("oe_n reset", 8'h01, &pin_oe_n);
        for (int i = 0; i < 5; i++)
        begin
            bus(0, di[i], 8'h0);
            chk("dir reset", 8'h00, rdv);
            bus(1, di[i] - 8'h2, 8'h96);
            if (i == 0)
                bus(1, 8'hf8, 8'h04);
            bus(1, di[i], 8'ha5);
            dm = 8'ha5 & mk[i];
            bus(0, di[i], 8'h0);
            chk("dir read", dm, rdv);
            chk("oe_n", ~dm, pin_oe_n[i*8 +: 8]);
            chk("out", 8'h96 & dm, pin_out[i*8 +: 8] & dm);
            bus(0, di[i] - 8'h2, 8'h0);
            ex = (8'h96 & dm) | (ext_val[i*8 +: 8] & ~dm
                & (mk[i] | (i == 4 ? 8'h04 : 8'h00)));
            chk("data read", ex, rdv);
        end
        bus(1, 8'he2, 8'h00);
        bus(1, 8'hf8, 8'h04);
        bus(1, 8'he0, 8'h96);
        bus(1, 8'he2, 8'h00);
        bus(0, 8'he2, 8'h0);
        chk("locked dir", 8'ha5, rdv);
        bus(1, 8'hf8, 8'h04);
        bus(1, 8'he2, 8'h00);
        bus(0, 8'he2, 8'h0);
        chk("unlocked dir", 8'h00, rdv);
        ext_drv[7:4] <= 4'h0;
        bus(1, 8'hf0, 8'h02);
        bus(0, 8'he0, 8'h0);
        chk("pullup", 8'hf0, pin_pullup[7:0]);
        chk("pulled read", 8'hf0, rdv & 8'hf0);
        bus(1, 8'hf8, 8'h04);
        bus(1, 8'he2, 8'hff);
        @(posedge mclk);
        chk("pullup output", 8'h00, pin_pullup[7:0]);
        ext_drv[7:4] <= 4'hf;
        periph_out_en[9:8] <= 2'b11;
        periph_out[9:8] <= 2'b11;
        repeat (2) @(posedge mclk);
        chk("periph", 8'h03, {pin_oe_n[9:8], pin_out[9:8]});
        periph_out_en[9:8] <= 2'b00;
        repeat (2) @(posedge mclk);
        chk("periph off", 8'h08, {pin_oe_n[9:8], pin_out[9:8]});
        bus(1, 8'he8, 8'hff);
        xtal_in_use <= 1'b1;
        adc_in_use <= 1'b1;
        bus(0, 8'he8, 8'h0);
        chk("p4 shared", 8'h20, rdv);
        chk("xtal oe_n", 8'h03, pin_oe_n[39:38]);
        xtal_in_use <= 1'b0;
        adc_in_use <= 1'b0;
        bus(0, 8'he8, 8'h0);
        chk("p4 free", 8'he4, rdv);
        bus(1, 8'hf2, 8'h5a);
        bus(1, 8'hf4, 8'h01);
        bus(1, 8'hf6, 8'h24);
        bus(1, 8'hf7, 8'h0e);
        @(posedge mclk);
        chk("drive p1", 8'h5a, pin_drive_high[15:8]);
        chk("drive p0", 8'h0f, pin_drive_high[7:0]);
        chk("thr low", 8'h24, thresh_code_low);
        chk("thr high", 8'h0e, thresh_code_high);
        bus(1, 8'hf6, 8'h1b);
        bus(0, 8'hf6, 8'h0);
        chk("thr read", 8'h1b, rdv);
        bus(1, 8'hf1, 8'h0f);
        bus(1, 8'hf3, 8'h05);
        bus(1, 8'hf5, 8'h07);
        @(posedge mclk);
        chk("pullup p2", 8'h02, pin_pullup[23:16]);
        chk("pullup p3", 8'h1a, pin_pullup[31:24]);
        chk("pullup p4", 8'h40, pin_pullup[39:32]);
        chk("drive p2", 8'h05, pin_drive_high[23:16]);
        chk("drive p3", 8'hba, pin_drive_high[31:24]);
        chk("drive p4", 8'he0, pin_drive_high[39:32]);
        avs_byteenable <= 4'h0;
        bus(1, 8'hf6, 8'h3f);
        avs_byteenable <= 4'h1;
        bus(0, 8'hf6, 8'h0);
        chk("lane off", 8'h1b, rdv);
        bus(1, 8'hf8, 8'h04);
        bus(0, 8'hf8, 8'h0);
        chk("unlock read", 8'h04, rdv);
        bus(1, 8'h10, 8'h55);
        bus(0, 8'h10, 8'h0);
        chk("unmapped", 8'h00, rdv);
        bus(0, 8'hf8, 8'h0);
        chk("unlock cleared", 8'h00, rdv);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        bus(0, 8'he3, 8'h0);
        chk("dir rereset", 8'h00, rdv);
        chk("oe_n rereset", 8'h01, &pin_oe_n);
        stop_test();
    end
endmodule
`default_nettype wire
